// [shared/lcdc_pkg.sv]
// Package with command codes, field positions, reset values and timing counts
`default_nettype none
package lcdc_pkg;
	// Clock rate
	localparam int CLK_HZ = 200_000_000;
	// Indicator blink periods, in milliseconds
	localparam int BLINK_SLOW_MS = 1000;
	localparam int BLINK_FAST_MS = 500;
	localparam int BLINK_SLOW_CYC = CLK_HZ / 1000 * BLINK_SLOW_MS / 2;
	localparam int BLINK_FAST_CYC = CLK_HZ / 1000 * BLINK_FAST_MS / 2;
	// Command codes, full byte
	localparam logic [7:0] CMD_DISP_OFF = 8'hAE;
	localparam logic [7:0] CMD_DISP_ON = 8'hAF;
	localparam logic [7:0] CMD_SEG_NORM = 8'hA0;
	localparam logic [7:0] CMD_SEG_REV = 8'hA1;
	localparam logic [7:0] CMD_INV_OFF = 8'hA6;
	localparam logic [7:0] CMD_INV_ON = 8'hA7;
	localparam logic [7:0] CMD_ALL_OFF = 8'hA4;
	localparam logic [7:0] CMD_ALL_ON = 8'hA5;
	localparam logic [7:0] CMD_BIAS_9 = 8'hA2;
	localparam logic [7:0] CMD_BIAS_7 = 8'hA3;
	localparam logic [7:0] CMD_RMW = 8'hE0;
	localparam logic [7:0] CMD_END = 8'hEE;
	localparam logic [7:0] CMD_RESET = 8'hE2;
	localparam logic [7:0] CMD_NOP = 8'hE3;
	localparam logic [7:0] CMD_VOL_MODE = 8'h81;
	localparam logic [7:0] CMD_IND_OFF = 8'hAC;
	localparam logic [7:0] CMD_IND_ON = 8'hAD;
	// Command prefixes
	localparam logic [1:0] PFX_START = 2'h1;
	localparam logic [3:0] PFX_PAGE = 4'hB;
	localparam logic [3:0] PFX_COL_HI = 4'h1;
	localparam logic [3:0] PFX_COL_LO = 4'h0;
	localparam logic [3:0] PFX_COM = 4'hC;
	localparam logic [4:0] PFX_POWER = 5'h05;
	localparam logic [4:0] PFX_RATIO = 5'h04;
	localparam logic [3:0] PFX_TEST = 4'hF;
	// Field positions
	localparam int COM_DIR_BIT = 3;
	localparam int STAT_BUSY_BIT = 7;
	localparam int STAT_ADC_BIT = 6;
	localparam int STAT_ON_BIT = 5;
	localparam int STAT_RST_BIT = 4;
	// Reset values
	localparam logic [5:0] RST_VOLUME = 6'h20;
	localparam logic [2:0] RST_RATIO = 3'h0;
	localparam logic [1:0] RST_BLINK = 2'h0;
	// Indicator blink modes
	localparam logic [1:0] BLINK_OFF = 2'h0;
	localparam logic [1:0] BLINK_SLOW = 2'h1;
	localparam logic [1:0] BLINK_FAST = 2'h2;
	localparam logic [1:0] BLINK_STEADY = 2'h3;
	// Power state, one-hot
	typedef enum logic [2:0] {
		PWR_RUN = 3'b001,
		PWR_STANDBY = 3'b010,
		PWR_SLEEP = 3'b100
	} lcdc_pwr_t;
endpackage
`default_nettype wire

// [hw/lcdc_fifo.sv]
// Host byte queue: its module sits beside the decoder in the decoder's file

// [hw/lcdc_cmd_decoder.sv]
// Command decoder with power save control for a dot-matrix LCD controller
`timescale 1ns/1ps
`default_nettype none

// =====================================================
// Host byte queue, valid/ready on both sides
module lcdc_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 4
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_param
		$error("lcdc_fifo: DEPTH must be a power of two of at least 2");
	end

	typedef struct packed {
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] cnt;
	} lcdc_fifo_st_t;

	lcdc_fifo_st_t st_q, st_d;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push, pop;

	assign inReady = st_q.cnt != (AW+1)'(DEPTH);
	assign outValid = st_q.cnt != '0;
	assign outData = mem[st_q.rd];
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	always_comb begin
		st_d = st_q;
		if (push)
			st_d.wr = st_q.wr + 1'b1;
		if (pop)
			st_d.rd = st_q.rd + 1'b1;
		if (push && !pop)
			st_d.cnt = st_q.cnt + 1'b1;
		else if (pop && !push)
			st_d.cnt = st_q.cnt - 1'b1;
	end

	always_ff @(posedge clock) begin
		if (!rst_n)
			st_q <= '0;
		else
			st_q <= st_d;
		if (push)
			mem[st_q.wr] <= inData;
	end
endmodule

// =====================================================
// Command decoder
module lcdc_cmd_decoder #(
	parameter int PAGES = 9,
	parameter int COLUMNS = 132,
	parameter int FIFO_DEPTH = 4,
	parameter int BLINK_SLOW_CYCLES = lcdc_pkg::BLINK_SLOW_CYC,
	parameter int BLINK_FAST_CYCLES = lcdc_pkg::BLINK_FAST_CYC
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic hard_reset_n,
	input wire logic wrValid,
	output logic wrReady,
	input wire logic cmd_data_select,
	input wire logic [7:0] wrData,
	input wire logic rdReq,
	input wire logic rdSelect,
	output logic rdValid,
	output logic [7:0] rdData,
	output logic displayOn,
	output logic [5:0] startLine,
	output logic [3:0] pageAddr,
	output logic [7:0] columnAddr,
	output logic segReverse,
	output logic displayInvert,
	output logic allPointsOn,
	output logic bias7,
	output logic comReverse,
	output logic [2:0] powerStages,
	output logic [2:0] regRatio,
	output logic [5:0] volume,
	output logic [1:0] blinkMode,
	output logic indicatorOut,
	output logic rmwActive,
	output logic testMode,
	output logic sleepMode,
	output logic standbyMode,
	output logic oscEnable,
	output logic supplyEnable,
	output logic panelDriveEnable,
	output logic display_off_output_n
);
	if (PAGES < 1 || PAGES > 16 || COLUMNS < 1 || COLUMNS > 256 ||
			BLINK_SLOW_CYCLES < 1 || BLINK_FAST_CYCLES < 1) begin : g_bad_param
		$error("lcdc_cmd_decoder: parameter out of range");
	end

	localparam int RAM_WORDS = PAGES * COLUMNS;
	localparam int RAW = $clog2(RAM_WORDS);

	// =====================================================
	// State
	typedef struct packed {
		logic dispOn;
		logic [5:0] start;
		logic [3:0] page;
		logic [7:0] col;
		logic [7:0] colSave;
		logic segRev;
		logic inv;
		logic allOn;
		logic b7;
		logic comRev;
		logic [2:0] pwr;
		logic [2:0] ratio;
		logic [5:0] vol;
		logic indOn;
		logic [1:0] blink;
		logic volPending;
		logic indPending;
		logic rmw;
		logic test;
		lcdc_pkg::lcdc_pwr_t pmode;
		logic [31:0] blinkCnt;
		logic indLevel;
		logic rdV;
		logic [7:0] rdD;
		logic rstFlag;
	} lcdc_st_t;

	lcdc_st_t st_q, st_d;
	logic [7:0] ram [RAM_WORDS];

	logic fValid, fReady;
	logic [8:0] fData;
	logic isData;
	logic [7:0] b;
	logic doWrite;
	logic [RAW-1:0] ramIdx;

	lcdc_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clock(clock),
		.rst_n(rst_n && hard_reset_n),
		.inValid(wrValid),
		.inReady(wrReady),
		.inData({cmd_data_select, wrData}),
		.outValid(fValid),
		.outReady(fReady),
		.outData(fData)
	);

	// Reads take priority; the FIFO drains one byte per idle cycle
	assign fReady = !rdReq;
	assign isData = fData[8];
	assign b = fData[7:0];
	assign ramIdx = RAW'(32'(st_q.page) * COLUMNS + 32'(st_q.col));
	assign doWrite = fValid && fReady && isData &&
		32'(st_q.page) < PAGES && 32'(st_q.col) < COLUMNS;

	// =====================================================
	// Next state
	always_comb begin
		logic [31:0] limit;
		limit = '0;
		st_d = st_q;
		st_d.rdV = 1'b0;
		// Indicator drive keeps running in standby; stops in sleep, in blink mode off or with the indicator off
		limit = (st_q.blink == lcdc_pkg::BLINK_FAST) ?
			32'(BLINK_FAST_CYCLES) : 32'(BLINK_SLOW_CYCLES);
		if (st_q.pmode == lcdc_pkg::PWR_SLEEP ||
				st_q.blink == lcdc_pkg::BLINK_OFF ||
				!st_q.indOn) begin
			st_d.blinkCnt = '0;
			st_d.indLevel = 1'b0;
		end else if (st_q.blink == lcdc_pkg::BLINK_STEADY) begin
			st_d.blinkCnt = '0;
			st_d.indLevel = 1'b1;
		end else if (st_q.blinkCnt >= limit - 32'd1) begin
			st_d.blinkCnt = '0;
			st_d.indLevel = !st_q.indLevel;
		end else begin
			st_d.blinkCnt = st_q.blinkCnt + 32'd1;
		end

		if (rdReq) begin
			st_d.rdV = 1'b1;
			if (rdSelect) begin
				st_d.rdD = ram[ramIdx];
				if (!st_q.rmw && st_q.col < 8'(COLUMNS - 1))
					st_d.col = st_q.col + 8'h01;
			end else begin
				st_d.rdD = 8'h00;
				st_d.rdD[lcdc_pkg::STAT_BUSY_BIT] = 1'b0;
				st_d.rdD[lcdc_pkg::STAT_ADC_BIT] = st_q.segRev;
				st_d.rdD[lcdc_pkg::STAT_ON_BIT] = !st_q.dispOn;
				st_d.rdD[lcdc_pkg::STAT_RST_BIT] = st_q.rstFlag;
			end
		end else if (fValid) begin
			st_d.rstFlag = 1'b0;
			if (isData) begin
				if (st_q.col < 8'(COLUMNS - 1))
					st_d.col = st_q.col + 8'h01;
			end else if (st_q.test) begin
				// Test mode swallows all commands; NOP or reset only ends it
				if (b == lcdc_pkg::CMD_NOP || b == lcdc_pkg::CMD_RESET)
					st_d.test = 1'b0;
			end else if (st_q.volPending) begin
				st_d.vol = b[5:0];
				st_d.volPending = 1'b0;
			end else if (st_q.indPending) begin
				st_d.blink = b[1:0];
				st_d.indPending = 1'b0;
			end else if (b[7:6] == lcdc_pkg::PFX_START) begin
				st_d.start = b[5:0];
			end else if (b[7:4] == lcdc_pkg::PFX_PAGE) begin
				st_d.page = b[3:0];
			end else if (b[7:4] == lcdc_pkg::PFX_COL_HI) begin
				if (!st_q.rmw)
					st_d.col = {b[3:0], st_q.col[3:0]};
			end else if (b[7:4] == lcdc_pkg::PFX_COL_LO) begin
				if (!st_q.rmw)
					st_d.col = {st_q.col[7:4], b[3:0]};
			end else if (b[7:3] == lcdc_pkg::PFX_POWER) begin
				st_d.pwr = b[2:0];
			end else if (b[7:3] == lcdc_pkg::PFX_RATIO) begin
				st_d.ratio = b[2:0];
			end else if (b[7:4] == lcdc_pkg::PFX_COM) begin
				st_d.comRev = b[lcdc_pkg::COM_DIR_BIT];
			end else begin
				case (b)
					lcdc_pkg::CMD_DISP_OFF, lcdc_pkg::CMD_DISP_ON: begin
						st_d.dispOn = b[0];
						if (b[0])
							st_d.pmode = lcdc_pkg::PWR_RUN;
					end
					lcdc_pkg::CMD_SEG_NORM, lcdc_pkg::CMD_SEG_REV:
						st_d.segRev = b[0];
					lcdc_pkg::CMD_INV_OFF, lcdc_pkg::CMD_INV_ON:
						st_d.inv = b[0];
					lcdc_pkg::CMD_ALL_OFF: begin
						st_d.allOn = 1'b0;
						st_d.pmode = lcdc_pkg::PWR_RUN;
					end
					lcdc_pkg::CMD_ALL_ON: begin
						st_d.allOn = 1'b1;
						if (!st_q.dispOn)
							st_d.pmode = st_q.indOn ?
								lcdc_pkg::PWR_STANDBY : lcdc_pkg::PWR_SLEEP;
					end
					lcdc_pkg::CMD_BIAS_9, lcdc_pkg::CMD_BIAS_7:
						st_d.b7 = b[0];
					lcdc_pkg::CMD_RMW: begin
						if (!st_q.rmw)
							st_d.colSave = st_q.col;
						st_d.rmw = 1'b1;
					end
					lcdc_pkg::CMD_END: begin
						if (st_q.rmw)
							st_d.col = st_q.colSave;
						st_d.rmw = 1'b0;
					end
					lcdc_pkg::CMD_RESET: begin
						st_d.start = '0;
						st_d.col = '0;
						st_d.page = '0;
						st_d.comRev = 1'b0;
						st_d.ratio = lcdc_pkg::RST_RATIO;
						st_d.vol = lcdc_pkg::RST_VOLUME;
						st_d.indOn = 1'b0;
						st_d.blink = lcdc_pkg::RST_BLINK;
						st_d.rmw = 1'b0;
						if (st_q.pmode == lcdc_pkg::PWR_STANDBY)
							st_d.pmode = lcdc_pkg::PWR_SLEEP;
					end
					lcdc_pkg::CMD_NOP: ;
					lcdc_pkg::CMD_VOL_MODE:
						st_d.volPending = 1'b1;
					lcdc_pkg::CMD_IND_OFF:
						st_d.indOn = 1'b0;
					lcdc_pkg::CMD_IND_ON: begin
						st_d.indOn = 1'b1;
						st_d.indPending = 1'b1;
					end
					default: begin
						if (b[7:4] == lcdc_pkg::PFX_TEST)
							st_d.test = 1'b1;
						// Other codes change nothing
					end
				endcase
			end
		end
	end

	// =====================================================
	// Registers; hard reset pin or rst_n both initialise control state
	always_ff @(posedge clock) begin
		if (!rst_n || !hard_reset_n) begin
			st_q <= '0;
			st_q.vol <= lcdc_pkg::RST_VOLUME;
			st_q.ratio <= lcdc_pkg::RST_RATIO;
			st_q.blink <= lcdc_pkg::RST_BLINK;
			st_q.pmode <= lcdc_pkg::PWR_RUN;
			st_q.rstFlag <= 1'b1;
		end else begin
			st_q <= st_d;
		end
		// RAM survives power save and the reset command
		if (doWrite)
			ram[ramIdx] <= b;
	end

	// =====================================================
	// Outputs, all from st_q
	always_comb begin
		displayOn = st_q.dispOn;
		startLine = st_q.start;
		pageAddr = st_q.page;
		columnAddr = st_q.col;
		segReverse = st_q.segRev;
		displayInvert = st_q.inv;
		allPointsOn = st_q.allOn;
		bias7 = st_q.b7;
		comReverse = st_q.comRev;
		powerStages = st_q.pwr;
		regRatio = st_q.ratio;
		volume = st_q.vol;
		blinkMode = st_q.blink;
		indicatorOut = st_q.indLevel;
		rmwActive = st_q.rmw;
		testMode = st_q.test;
		rdValid = st_q.rdV;
		rdData = st_q.rdD;
		sleepMode = st_q.pmode == lcdc_pkg::PWR_SLEEP;
		standbyMode = st_q.pmode == lcdc_pkg::PWR_STANDBY;
		oscEnable = st_q.pmode != lcdc_pkg::PWR_SLEEP;
		supplyEnable = st_q.pmode == lcdc_pkg::PWR_RUN;
		panelDriveEnable = st_q.pmode == lcdc_pkg::PWR_RUN;
		display_off_output_n = st_q.pmode == lcdc_pkg::PWR_RUN;
	end
endmodule
`default_nettype wire

// [bench/lcdc_host_model.sv]
// Host model that writes bytes and issues reads to the decoder
`timescale 1ns/1ps
`default_nettype none
module lcdc_host_model (
	input wire logic clock,
	input wire logic wrReady,
	input wire logic stall,
	output logic wrValid,
	output logic cmd_data_select,
	output logic [7:0] wrData,
	output var logic rdReq,
	output logic rdSelect
);
	logic pulse = 1'b0;
	assign rdReq = pulse | stall;
	initial begin
		wrValid = 1'b0;
		cmd_data_select = 1'b0;
		wrData = 8'h00;
		rdSelect = 1'b0;
	end
	// Byte is held until an edge with room in the queue takes it
	task automatic send(input logic ds, input logic [7:0] b);
		@(negedge clock);
		wrValid = 1'b1;
		cmd_data_select = ds;
		wrData = b;
		while (!wrReady) @(negedge clock);
		@(negedge clock);
		wrValid = 1'b0;
		wrData = ~b;
	endtask
	task automatic read(input logic s);
		@(negedge clock);
		pulse = 1'b1;
		rdSelect = s;
		@(negedge clock);
		pulse = 1'b0;
		rdSelect = ~s;
	endtask
endmodule
`default_nettype wire

// [bench/lcdc_cmd_decoder_assertions.sv]
// Checker for the power save and read port behaviour
`timescale 1ns/1ps
`default_nettype none
module lcdc_cmd_decoder_assertions (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic hard_reset_n,
	input wire logic rdReq,
	input wire logic rdSelect,
	input wire logic rdValid,
	input wire logic [7:0] rdData,
	input wire logic displayOn,
	input wire logic [5:0] startLine,
	input wire logic [3:0] pageAddr,
	input wire logic [1:0] blinkMode,
	input wire logic indicatorOut,
	input wire logic sleepMode,
	input wire logic standbyMode,
	input wire logic oscEnable,
	input wire logic supplyEnable,
	input wire logic panelDriveEnable,
	input wire logic display_off_output_n
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n || !hard_reset_n);
	sequence held3(logic [1:0] m);
		(blinkMode == m) [*3];
	endsequence
	a_sleep_halts: assert property (sleepMode |-> !oscEnable &&
		!supplyEnable && !panelDriveEnable) else $error("sleep drive on");
	a_standby_osc: assert property (standbyMode |-> oscEnable &&
		!supplyEnable && !panelDriveEnable) else $error("standby drive");
	a_dof_follows: assert property (display_off_output_n ==
		!(sleepMode || standbyMode)) else $error("display-off pin");
	a_one_mode: assert property (!(sleepMode && standbyMode))
		else $error("two save modes");
	a_save_entry: assert property ($rose(sleepMode || standbyMode) |->
		!displayOn && $stable(startLine) && $stable(pageAddr))
		else $error("bad power save entry");
	a_read_answer: assert property (rdReq |=> rdValid)
		else $error("read not answered");
	a_read_once: assert property (!rdReq |=> !rdValid)
		else $error("spurious read answer");
	a_status_zero: assert property (rdReq && !rdSelect |=>
		rdData[3:0] == 4'h0 && !rdData[7]) else $error("status bits");
	a_blink_off: assert property (held3(lcdc_pkg::BLINK_OFF) |->
		!indicatorOut) else $error("indicator lit");
endmodule
bind lcdc_cmd_decoder lcdc_cmd_decoder_assertions
	lcdc_cmd_decoder_assertions_i (.clock, .rst_n, .hard_reset_n, .rdReq,
	.rdSelect, .rdValid, .rdData, .displayOn, .startLine, .pageAddr,
	.blinkMode, .indicatorOut, .sleepMode, .standbyMode, .oscEnable,
	.supplyEnable, .panelDriveEnable, .display_off_output_n);
`default_nettype wire

// [bench/lcdc_cmd_decoder_test.sv]
// Self-checking bench for the LCD command decoder
`timescale 1ns/1ps
`default_nettype none
module lcdc_cmd_decoder_test;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic hard_reset_n = 1'b1;
	logic stall = 1'b0;
	logic wrValid, wrReady, cmd_data_select, rdReq, rdSelect, rdValid;
	logic displayOn, segReverse, displayInvert, allPointsOn, bias7;
	logic comReverse, indicatorOut, rmwActive, testMode, sleepMode, prev;
	logic standbyMode, oscEnable, supplyEnable, panelDriveEnable;
	logic display_off_output_n;
	logic [7:0] wrData, rdData, columnAddr;
	logic [5:0] startLine, volume;
	logic [3:0] pageAddr;
	logic [2:0] powerStages, regRatio;
	logic [1:0] blinkMode;
	int n_fail = 0;
	int total_checks = 0;
	int cycles = 0;
	int toggles;
	logic [7:0] rowCmd [10] = '{8'hAF, 8'hA3, 8'hCF, 8'hC7, 8'h7F, 8'hB5,
		8'h2D, 8'hE7, 8'hAE, 8'hA2};
	logic [15:0] rowExp [10] = '{16'h8000, 16'hC000, 16'hE000, 16'hC000,
		16'hDF80, 16'hDFA8, 16'hDFAD, 16'hDFAD, 16'h5FAD, 16'h1FAD};
	always #2.5 clock = ~clock;
	lcdc_cmd_decoder #(.BLINK_SLOW_CYCLES(10), .BLINK_FAST_CYCLES(5))
		lcdc_cmd_decoder_i (.clock, .rst_n, .hard_reset_n, .wrValid,
		.wrReady, .cmd_data_select, .wrData, .rdReq, .rdSelect, .rdValid,
		.rdData, .displayOn, .startLine, .pageAddr, .columnAddr, .segReverse,
		.displayInvert, .allPointsOn, .bias7, .comReverse, .powerStages,
		.regRatio, .volume, .blinkMode, .indicatorOut, .rmwActive, .testMode,
		.sleepMode, .standbyMode, .oscEnable, .supplyEnable,
		.panelDriveEnable, .display_off_output_n);
	lcdc_host_model lcdc_host_model_i (.clock, .wrReady, .stall, .wrValid,
		.cmd_data_select, .wrData, .rdReq, .rdSelect);
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic put(input logic ds, input logic [7:0] b);
		lcdc_host_model_i.send(ds, b);
		repeat (4) @(negedge clock);
	endtask
	task automatic cmd(input logic [7:0] b);
		put(1'b0, b);
	endtask
	task automatic rd(input logic s);
		lcdc_host_model_i.read(s);
		chk("answer", 16'h0001, 16'(rdValid));
	endtask
	function automatic logic [15:0] pwr();
		return 16'({sleepMode, standbyMode, oscEnable, supplyEnable,
			panelDriveEnable, display_off_output_n});
	endfunction
	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	always @(posedge clock) begin
		cycles++;
		if (cycles == 6000) begin
			n_fail++;
			results();
		end
	end
	initial begin
		repeat (2) @(negedge clock);
		rst_n = 1'b1;
		rd(1'b0);
		chk("status", 16'h0030, 16'(rdData));
		for (int i = 0; i < 10; i++) begin
			cmd(rowCmd[i]);
			chk("settings", rowExp[i], {displayOn, bias7, comReverse,
				startLine, pageAddr, powerStages});
		end
		cmd(8'hA1);
		cmd(8'hA7);
		cmd(8'h25);
		chk("modes", 16'h001D,
			16'({segReverse, displayInvert, regRatio}));
		cmd(8'hA1);
		chk("refresh", 16'h001D,
			16'({segReverse, displayInvert, regRatio}));
		rd(1'b0);
		chk("status", 16'h0060, 16'(rdData));
		$display("command rows done");
		cmd(8'h13);
		cmd(8'h04);
		chk("column", 16'h0034, 16'(columnAddr));
		cmd(8'h0A);
		cmd(8'h12);
		chk("column", 16'h002A, 16'(columnAddr));
		$display("column test done");
		cmd(8'hB0);
		cmd(8'h11);
		cmd(8'h00);
		cmd(8'hE0);
		put(1'b1, 8'hA5);
		chk("column", 16'h0111, 16'({rmwActive, columnAddr}));
		rd(1'b1);
		chk("column", 16'h0011, 16'(columnAddr));
		cmd(8'hEE);
		chk("column", 16'h0010, 16'({rmwActive, columnAddr}));
		rd(1'b1);
		chk("ram", 16'h00A5, 16'(rdData));
		$display("read modify write test done");
		cmd(8'h81);
		cmd(8'hAF);
		chk("volume", 16'h002F, 16'({displayOn, volume}));
		cmd(8'hAD);
		cmd(8'hFE);
		chk("blink", 16'h0002, 16'(blinkMode));
		toggles = 0;
		repeat (60) begin
			prev = indicatorOut;
			@(negedge clock);
			if (indicatorOut !== prev) toggles++;
		end
		chk("toggles", 16'h000C, 16'(toggles));
		cmd(8'hAC);
		chk("indicator", 16'h0000, 16'(indicatorOut));
		$display("indicator test done");
		cmd(8'hA5);
		chk("power", 16'h0020, pwr());
		chk("start", 16'h007F, 16'({allPointsOn, startLine}));
		cmd(8'hA4);
		chk("power", 16'h000F, pwr());
		cmd(8'hAD);
		cmd(8'h03);
		cmd(8'hA5);
		chk("power", 16'h0018, pwr());
		chk("indicator", 16'h0001, 16'(indicatorOut));
		cmd(8'hE2);
		chk("power", 16'h0020, pwr());
		$display("power save test done");
		cmd(8'hF0);
		cmd(8'hB3);
		chk("test", 16'h0010, 16'({testMode, pageAddr}));
		cmd(8'hE3);
		chk("test", 16'h0000, 16'(testMode));
		cmd(8'hF0);
		cmd(8'hE2);
		chk("test", 16'h0000, 16'(testMode));
		cmd(8'hF7);
		chk("test", 16'h0001, 16'(testMode));
		hard_reset_n = 1'b0;
		repeat (2) @(negedge clock);
		hard_reset_n = 1'b1;
		chk("test", 16'h0000, 16'(testMode));
		$display("test mode test done");
		stall = 1'b1;
		for (int i = 1; i < 5; i++) lcdc_host_model_i.send(1'b0, 8'hB0 + 8'(i));
		chk("ready", 16'h0000, 16'(wrReady));
		stall = 1'b0;
		repeat (8) @(negedge clock);
		chk("page", 16'h0014, 16'({wrReady, pageAddr}));
		$display("buffer test done");
		rst_n = 1'b0;
		repeat (2) @(negedge clock);
		rst_n = 1'b1;
		chk("reset", 16'h0020, 16'({displayOn, startLine, volume}));
		rd(1'b0);
		chk("status", 16'h0030, 16'(rdData));
		$display("reset test done");
		results();
	end
endmodule
`default_nettype wire
